/* common/sweep_pkg.sv */
// Shared constants, enums and carrier structs for the sweep capture controller.
// Assumes a single 100 MHz clock domain and an APB slave for software access.
package sweep_pkg;

  localparam int CLK_MHZ = 100;
  localparam int CLK_HZ = 100_000_000;

  // Sweep spacing and stretch spacing, 2.5 ms
  localparam int SPACING_US = 2500;
  localparam int SPACING_CYC = SPACING_US * CLK_MHZ;
  // Longest delayed trigger, in seconds
  localparam int DELAY_MAX_S = 1000;
  localparam longint DELAY_MAX_CYC = longint'(DELAY_MAX_S) * longint'(CLK_HZ);
  localparam int SWEEP_MAX = 200000;
  localparam int SWITCH_MAX = 200000;
  localparam int SLOW_RATE_MAX_HZ = 50000;

  localparam int SAMPLE_W = 27;
  localparam int DELAY_W = 37;
  localparam int CNT_W = 18;
  localparam int SLOT_CNT = 2;
  localparam int SLOT_W = 1;

  // APB map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LEN_OFF = 8'h04;
  localparam logic [7:0] PRE_OFF = 8'h08;
  localparam logic [7:0] DLY_LO_OFF = 8'h0C;
  localparam logic [7:0] DLY_HI_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] SWEEPS_OFF = 8'h18;
  localparam logic [7:0] MARKS_OFF = 8'h1C;
  localparam logic [7:0] SWITCH_OFF = 8'h20;
  localparam logic [7:0] RATE_OFF = 8'h24;

  // CTRL fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_STRETCH = 3;
  localparam int CTRL_DELAY_EN = 4;
  localparam int CTRL_CHAN_LSB = 8;

  localparam logic [SAMPLE_W-1:0] LEN_RESET = 27'h0000400;
  localparam logic [SAMPLE_W-1:0] PRE_RESET = 27'h0000000;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MULTI = 2'b01,
    MODE_SLOWFAST = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_DELAY = 3'b010,
    ST_POST = 3'b011,
    ST_DONE = 3'b100
  } state_e;

  typedef struct packed {
    logic run;
    mode_e mode;
    logic stretch;
    logic delay_en;
    logic [7:0] chan_en;
    logic [SAMPLE_W-1:0] len;
    logic [SAMPLE_W-1:0] pre;
    logic [DELAY_W-1:0] delay;
    logic [15:0] slow_div;
    logic [15:0] fast_div;
  } cfg_s;

  typedef struct packed {
    logic valid;
    logic marker;
    logic [SLOT_W-1:0] slot;
    logic [SAMPLE_W-1:0] pre_kept;
    logic [SAMPLE_W-1:0] length;
  } sweep_desc_s;

endpackage : sweep_pkg

/* dv/sweep_capture_controller_tb.sv */
// Self-checking bench for the sweep capture controller, driven over APB.
// Assumes the storage model on the far side; each scenario starts from a reset.
`timescale 1ns/1ps
module sweep_capture_controller_tb;
  logic clk, rst, psel, penable, pwrite, trig, sample_tick, fast_req, stall;
  logic pready, pslverr, capture_en, fast_rate, desc_valid, desc_marker, desc_ready;
  logic [7:0] paddr;
  logic [7:0] chan_done;
  logic [31:0] pwdata, prdata, rd;
  logic [sweep_pkg::SLOT_W-1:0] desc_slot, done_slot;
  logic [sweep_pkg::SAMPLE_W-1:0] desc_pre, desc_len;
  int stored, fails, num_checks;

  sweep_capture_controller i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .trig, .sample_tick, .fast_req, .capture_en, .fast_rate,
    .desc_valid, .desc_marker, .desc_slot, .desc_pre, .desc_len, .desc_ready, .chan_done,
    .done_slot);

  sweep_store_model i_store (.clk, .rst, .stall, .chan_mask(8'h03), .desc_valid, .desc_marker,
    .desc_slot, .desc_ready, .chan_done, .done_slot, .stored);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'(pready), 32'h00000001);
    check("pslverr", 32'(pslverr), 32'h00000000);
  endtask : apb

  task automatic wait_on(ref logic s, input logic v, input int lim, input string what);
    int n;
    n = 0;
    do
      @(posedge clk);
    while (s !== v && ++n < lim);
    check(what, 32'(s), 32'(v));
  endtask : wait_on

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
    end
  endtask : tick

  task automatic fire();
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask : fire

  // Fresh reset per sweep: the 2.5 ms spacing is far longer than the run
  task automatic start(input logic [31:0] len, pre, ctrl, dly);
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, sweep_pkg::LEN_OFF, len);
    apb(1'b1, sweep_pkg::PRE_OFF, pre);
    apb(1'b1, sweep_pkg::DLY_LO_OFF, dly);
    apb(1'b1, sweep_pkg::DLY_HI_OFF, 32'h00000000);
    // Slow divider 2000 keeps the slow rate at 50 kS/s and below half the fast rate
    apb(1'b1, sweep_pkg::RATE_OFF, 32'h07D00002);
    apb(1'b1, sweep_pkg::CTRL_OFF, ctrl | 32'h00000301);
    repeat (2) @(posedge clk);
  endtask : start

  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, trig, sample_tick, fast_req, stall} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    fails = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, sweep_pkg::LEN_OFF, 32'h00000000);
    check("len reset", rd, 32'(sweep_pkg::LEN_RESET));
    apb(1'b0, sweep_pkg::PRE_OFF, 32'h00000000);
    check("pre reset", rd, 32'(sweep_pkg::PRE_RESET));
    apb(1'b1, 8'hFC, 32'hFFFFFFFF);
    apb(1'b0, 8'hFC, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
    // No pre-trigger at all
    start(32'h10, 32'h0, 32'h0, 32'h0);
    fire();
    wait_on(desc_valid, 1'b1, 4, "desc at trigger");
    check("pre none", 32'(desc_pre), 32'h0);
    check("no marker", 32'(desc_marker), 32'h0);
    check("len", 32'(desc_len), 32'h10);
    check("slot", 32'(desc_slot), 32'h0);
    repeat (4) @(posedge clk);
    apb(1'b0, sweep_pkg::STAT_OFF, 32'h00000000);
    check("slot freed", rd, 32'(sweep_pkg::ST_POST));
    // Early trigger in multi mode with stretch on, then a retrigger inside the spacing
    start(32'h10, 32'h8, 32'hA, 32'h0);
    tick(3);
    fire();
    wait_on(desc_valid, 1'b1, 4, "desc early");
    check("pre kept", 32'(desc_pre), 32'h3);
    fire();
    repeat (12) @(posedge clk);
    check("retrigger", 32'(desc_valid), 32'h0);
    check("stored", 32'(stored), 32'h1);
    apb(1'b0, sweep_pkg::SWEEPS_OFF, 32'h00000000);
    check("sweeps", rd, 32'h1);
    apb(1'b0, sweep_pkg::MARKS_OFF, 32'h00000000);
    check("stretch refused", rd, 32'h1);
    // Full pre-trigger, storage slow to accept
    stall <= 1'b1;
    start(32'h6, 32'h6, 32'h0, 32'h0);
    tick(8);
    fire();
    wait_on(desc_valid, 1'b1, 4, "desc full");
    check("pre full", 32'(desc_pre), 32'h6);
    repeat (10) @(posedge clk);
    check("desc holds", 32'(desc_valid), 32'h1);
    stall <= 1'b0;
    wait_on(desc_valid, 1'b0, 8, "desc taken");
    // Delayed trigger: nothing kept before, recording starts at the delayed point
    stall <= 1'b1;
    start(32'h10, 32'h4, 32'h10, 32'd40);
    tick(5);
    fire();
    repeat (30) @(posedge clk);
    check("in delay", 32'(capture_en), 32'h0);
    wait_on(capture_en, 1'b1, 30, "delay over");
    wait_on(desc_valid, 1'b1, 30, "desc delay");
    check("pre delay", 32'(desc_pre), 32'h0);
    stall <= 1'b0;
    // Slow-fast: switches only after the trigger and never after the sweep
    fast_req <= 1'b1;
    start(32'h8, 32'h2, 32'h4, 32'h0);
    tick(2);
    check("fast in pre", 32'(fast_rate), 32'h0);
    fire();
    wait_on(fast_rate, 1'b1, 6, "fast in post");
    tick(12);
    wait_on(capture_en, 1'b0, 4, "sweep end");
    wait_on(fast_rate, 1'b0, 4, "fast after end");
    fast_req <= 1'b0;
    tally_and_finish();
  end
endmodule : sweep_capture_controller_tb

/* dv/sweep_store_model.sv */
// Behavioural host storage path: takes sweep descriptors, then reports channels done.
// Assumes one clock with the controller; stall keeps it slow to accept.
`timescale 1ns/1ps
module sweep_store_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic [7:0] chan_mask,
  input wire logic desc_valid,
  input wire logic desc_marker,
  input wire logic [sweep_pkg::SLOT_W-1:0] desc_slot,
  output logic desc_ready,
  output logic [7:0] chan_done,
  output logic [sweep_pkg::SLOT_W-1:0] done_slot,
  output int stored
);
  logic [7:0] left;
  logic [sweep_pkg::SLOT_W-1:0] cur;

  always_ff @(posedge clk)
  begin
    chan_done <= 8'h00;
    // Slot is meaningless between pulses, so it is scrambled there
    done_slot <= ~done_slot;
    if (rst)
    begin
      desc_ready <= 1'b0;
      left <= 8'h00;
      cur <= '0;
      stored <= 0;
      done_slot <= '0;
    end
    else if (desc_valid && desc_ready)
    begin
      desc_ready <= 1'b0;
      cur <= desc_slot;
      left <= desc_marker ? 8'h00 : chan_mask;
      stored <= stored + 1;
    end
    else if (left != 8'h00)
    begin
      // One channel per cycle, so release waits for the last one
      chan_done <= left & (~left + 8'h01);
      left <= left & (left - 8'h01);
      done_slot <= cur;
    end
    else
      desc_ready <= desc_valid && !stall;
  end
endmodule : sweep_store_model

/* rtl/spacing_timer.sv */
// Down-counter that marks when a minimum spacing has elapsed since its last restart.
// Assumes the restart pulse comes from the sweep controller on the same clock.
`timescale 1ns/1ps
module spacing_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  output logic open_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic open;
  } st_s;

  st_s state_reg;
  st_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (restart)
    begin
      state_next.cnt = 32'(sweep_pkg::SPACING_CYC - 1);
      state_next.open = 1'b0;
    end
    else if (state_reg.cnt != 32'h00000000)
    begin
      state_next.cnt = state_reg.cnt - 32'h00000001;
    end
    else
    begin
      state_next.open = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '{cnt: 32'h00000000, open: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign open_o = state_reg.open;

  spacing_closed_a: assert property (@(posedge clk) disable iff (rst)
    restart |=> !open_o [*8])
    else $error("spacing opened too early");

endmodule : spacing_timer

/* rtl/sweep_capture_controller.sv */
// Triggered sweep acquisition controller: single, multiple and slow-fast sweeps.
// Assumes trig and sample_tick are synchronous one-cycle pulses, storage handshakes on clk.
// Summary of operation
// - Pre-trigger length is programmable from zero up to the full sweep length.
// - Early trigger keeps only captured pre-trigger samples, shortening that segment.
// - Effective trigger may be delayed up to one thousand seconds.
// - Delayed trigger keeps no pre-trigger, records from the delayed point, whole sweep is post-trigger.
// - With stretch on, a post-trigger retrigger restarts the post count; the code never stretches a sweep started by a delayed trigger.
// - No stretch if the restarted post length no longer fits memory.
// - At most one stretch per 2.5 ms.
// - Multiple-sweep mode captures at most 200000 sweeps per recording.
// - Multiple-sweep mode captures at most 400 sweeps per second.
// - Zero re-arm time, but sweeps spaced by at least 2.5 ms.
// - Storage of a sweep starts as soon as its trigger is detected.
// - Sweep memory is freed only after all enabled channels are stored.
// - Sweeps are stored one at a time in capture order.
// - Triggers during overrun record only an event marker, no data.
// - Capture resumes at first trigger with room for a full sweep.
// - Slow rate is at most half the fast rate and 50 kS/s.
// - At most 400 rate switches per second, 200000 in total.
// - Rate switching stops once the sweep ends.
// - Slow-fast acts as single sweep, switches only in post-trigger segment.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sweep_capture_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig,
  input wire logic sample_tick,
  input wire logic fast_req,
  output logic capture_en,
  output logic fast_rate,
  output logic desc_valid,
  output logic desc_marker,
  output logic [sweep_pkg::SLOT_W-1:0] desc_slot,
  output logic [sweep_pkg::SAMPLE_W-1:0] desc_pre,
  output logic [sweep_pkg::SAMPLE_W-1:0] desc_len,
  input wire logic desc_ready,
  input wire logic [7:0] chan_done,
  input wire logic [sweep_pkg::SLOT_W-1:0] done_slot
);

  localparam int AW = sweep_pkg::SAMPLE_W;
  localparam int SLOT_CNT_W = sweep_pkg::SLOT_CNT;

  typedef struct packed {
    sweep_pkg::cfg_s cfg;
    sweep_pkg::state_e st;
    logic [AW-1:0] pre_cnt;
    logic [AW-1:0] post_cnt;
    logic [AW-1:0] used;
    logic [sweep_pkg::DELAY_W-1:0] dly_cnt;
    logic [sweep_pkg::CNT_W-1:0] sweeps;
    logic [sweep_pkg::CNT_W-1:0] marks;
    logic [sweep_pkg::CNT_W-1:0] switches;
    logic [SLOT_CNT_W-1:0] slot_busy;
    logic [SLOT_CNT_W*8-1:0] chan_seen;
    logic [sweep_pkg::SLOT_W-1:0] wr_slot;
    logic fast;
    logic [31:0] sw_gap;
    logic cap;
    sweep_pkg::sweep_desc_s desc;
    logic [31:0] rdata;
    logic ready;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic spacing_open;
  logic sweep_start;
  logic stretch_go;

  // One decode reused by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  spacing_timer u_spacing (
    .clk(clk),
    .rst(rst),
    .restart(sweep_start | stretch_go),
    .open_o(spacing_open)
  );

  always_comb
  begin
    logic [AW-1:0] post_len;
    logic room;
    logic [31:0] slow_min;
    post_len = state_reg.cfg.len - state_reg.cfg.pre;
    // Full sweep needs a free slot
    room = (state_reg.slot_busy[state_reg.wr_slot] == 1'b0);
    // Fast divider must be at most half the slow one, slow at most 50 kS/s
    slow_min = 32'(sweep_pkg::CLK_HZ / sweep_pkg::SLOW_RATE_MAX_HZ);
    state_next = state_reg;
    state_next.ready = 1'b0;
    sweep_start = 1'b0;
    stretch_go = 1'b0;
    state_next.desc.valid = state_reg.desc.valid & ~desc_ready;
    if (state_reg.sw_gap != 32'h00000000)
    begin
      state_next.sw_gap = state_reg.sw_gap - 32'h00000001;
    end

    // APB slave, one wait state
    if (psel && penable && !state_reg.ready)
    begin
      state_next.ready = 1'b1;
      state_next.rdata = 32'h00000000;
      if (pwrite)
      begin
        if (hit(paddr, sweep_pkg::CTRL_OFF))
        begin
          state_next.cfg.run = pwdata[sweep_pkg::CTRL_RUN];
          state_next.cfg.mode = sweep_pkg::mode_e'(pwdata[sweep_pkg::CTRL_MODE_LSB +: 2]);
          state_next.cfg.stretch = pwdata[sweep_pkg::CTRL_STRETCH];
          state_next.cfg.delay_en = pwdata[sweep_pkg::CTRL_DELAY_EN];
          state_next.cfg.chan_en = pwdata[sweep_pkg::CTRL_CHAN_LSB +: 8];
          if (pwdata[sweep_pkg::CTRL_RUN] && !state_reg.cfg.run)
          begin
            state_next.sweeps = '0;
            state_next.marks = '0;
            state_next.switches = '0;
          end
        end
        if (hit(paddr, sweep_pkg::LEN_OFF))
        begin
          state_next.cfg.len = pwdata[AW-1:0];
        end
        if (hit(paddr, sweep_pkg::PRE_OFF))
        begin
          // Clamp to the sweep length
          state_next.cfg.pre = (pwdata[AW-1:0] > state_reg.cfg.len) ?
                               state_reg.cfg.len : pwdata[AW-1:0];
        end
        if (hit(paddr, sweep_pkg::DLY_LO_OFF))
        begin
          state_next.cfg.delay[31:0] = pwdata;
        end
        if (hit(paddr, sweep_pkg::DLY_HI_OFF))
        begin
          state_next.cfg.delay[sweep_pkg::DELAY_W-1:32] = pwdata[sweep_pkg::DELAY_W-33:0];
        end
        if (hit(paddr, sweep_pkg::RATE_OFF))
        begin
          state_next.cfg.fast_div = pwdata[15:0];
          state_next.cfg.slow_div = pwdata[31:16];
        end
      end
      else
      begin
        case (1'b1)
          hit(paddr, sweep_pkg::CTRL_OFF): state_next.rdata = {16'h0000,
            state_reg.cfg.chan_en, 3'h0, state_reg.cfg.delay_en, state_reg.cfg.stretch,
            state_reg.cfg.mode, state_reg.cfg.run};
          hit(paddr, sweep_pkg::LEN_OFF): state_next.rdata = 32'(state_reg.cfg.len);
          hit(paddr, sweep_pkg::PRE_OFF): state_next.rdata = 32'(state_reg.cfg.pre);
          hit(paddr, sweep_pkg::DLY_LO_OFF): state_next.rdata = state_reg.cfg.delay[31:0];
          hit(paddr, sweep_pkg::DLY_HI_OFF):
            state_next.rdata = 32'(state_reg.cfg.delay[sweep_pkg::DELAY_W-1:32]);
          hit(paddr, sweep_pkg::STAT_OFF): state_next.rdata = {25'h0000000,
            state_reg.slot_busy, state_reg.fast, state_reg.desc.valid, state_reg.st};
          hit(paddr, sweep_pkg::SWEEPS_OFF): state_next.rdata = 32'(state_reg.sweeps);
          hit(paddr, sweep_pkg::MARKS_OFF): state_next.rdata = 32'(state_reg.marks);
          hit(paddr, sweep_pkg::SWITCH_OFF): state_next.rdata = 32'(state_reg.switches);
          hit(paddr, sweep_pkg::RATE_OFF):
            state_next.rdata = {state_reg.cfg.slow_div, state_reg.cfg.fast_div};
          default: state_next.rdata = 32'h00000000;
        endcase
      end
    end

    // Slot release once every enabled channel reports done
    for (int s = 0; s < sweep_pkg::SLOT_CNT; s++)
    begin
      if (chan_done != 8'h00 && done_slot == sweep_pkg::SLOT_W'(s))
      begin
        state_next.chan_seen[s*8 +: 8] = state_reg.chan_seen[s*8 +: 8] | chan_done;
      end
      if ((state_next.chan_seen[s*8 +: 8] & state_reg.cfg.chan_en) == state_reg.cfg.chan_en
          && state_reg.slot_busy[s])
      begin
        state_next.slot_busy[s] = 1'b0;
        state_next.chan_seen[s*8 +: 8] = 8'h00;
      end
    end

    case (state_reg.st)
      sweep_pkg::ST_IDLE:
      begin
        state_next.fast = 1'b0;
        if (state_reg.cfg.run)
        begin
          state_next.st = sweep_pkg::ST_PRE;
          state_next.pre_cnt = '0;
        end
      end
      sweep_pkg::ST_PRE:
      begin
        if (sample_tick && state_reg.pre_cnt < state_reg.cfg.pre)
        begin
          state_next.pre_cnt = state_reg.pre_cnt + 1'b1;
        end
        if (trig && spacing_open)
        begin
          if (!room)
          begin
            // Overrun: marker only, stay armed
            state_next.marks = state_reg.marks + 1'b1;
            state_next.desc = '{valid: 1'b1, marker: 1'b1, slot: state_reg.wr_slot,
                                pre_kept: '0, length: '0};
          end
          else
          begin
            sweep_start = 1'b1;
            state_next.slot_busy[state_reg.wr_slot] = 1'b1;
            state_next.post_cnt = state_reg.cfg.delay_en ? state_reg.cfg.len : post_len;
            state_next.used = state_reg.cfg.delay_en ? '0 : state_reg.pre_cnt;
            state_next.dly_cnt = state_reg.cfg.delay;
            state_next.st = state_reg.cfg.delay_en ? sweep_pkg::ST_DELAY : sweep_pkg::ST_POST;
            state_next.sweeps = state_reg.sweeps + 1'b1;
            // Storage is told about the sweep at trigger time
            state_next.desc = '{valid: 1'b1, marker: 1'b0, slot: state_reg.wr_slot,
              pre_kept: state_reg.cfg.delay_en ? '0 : state_reg.pre_cnt,
              length: state_reg.cfg.len};
          end
        end
      end
      sweep_pkg::ST_DELAY:
      begin
        if (state_reg.dly_cnt == '0)
        begin
          state_next.st = sweep_pkg::ST_POST;
        end
        else
        begin
          state_next.dly_cnt = state_reg.dly_cnt - 1'b1;
        end
      end
      sweep_pkg::ST_POST:
      begin
        if (sample_tick)
        begin
          state_next.post_cnt = state_reg.post_cnt - 1'b1;
          state_next.used = state_reg.used + 1'b1;
        end
        // Stretch needs the restarted post length to fit what is left
        if (trig && state_reg.cfg.stretch && spacing_open && !state_reg.cfg.delay_en &&
            (AW+1)'(state_reg.used) + (AW+1)'(post_len) <= (AW+1)'(state_reg.cfg.len))
        begin
          stretch_go = 1'b1;
          state_next.post_cnt = post_len;
        end
        else if (trig && state_reg.cfg.mode == sweep_pkg::MODE_MULTI)
        begin
          state_next.marks = state_reg.marks + 1'b1;
        end
        // Switches only inside post-trigger of a slow-fast sweep
        if (state_reg.cfg.mode == sweep_pkg::MODE_SLOWFAST && fast_req != state_reg.fast &&
            state_reg.sw_gap == '0 && 32'(state_reg.switches) < sweep_pkg::SWITCH_MAX &&
            32'(state_reg.cfg.slow_div) >= slow_min &&
            17'(state_reg.cfg.slow_div) >= {state_reg.cfg.fast_div, 1'b0})
        begin
          state_next.fast = fast_req;
          state_next.switches = state_reg.switches + 1'b1;
          state_next.sw_gap = 32'(sweep_pkg::SPACING_CYC - 1);
        end
        if (state_reg.post_cnt == '0 || (sample_tick && state_reg.post_cnt == AW'(1)))
        begin
          state_next.wr_slot = state_reg.wr_slot + 1'b1;
          state_next.fast = 1'b0;
          if (state_reg.cfg.mode == sweep_pkg::MODE_MULTI &&
              state_reg.sweeps < sweep_pkg::CNT_W'(sweep_pkg::SWEEP_MAX))
          begin
            state_next.st = sweep_pkg::ST_PRE;
            state_next.pre_cnt = '0;
          end
          else
          begin
            state_next.st = sweep_pkg::ST_DONE;
          end
        end
      end
      sweep_pkg::ST_DONE:
      begin
        state_next.fast = 1'b0;
        if (!state_reg.cfg.run)
        begin
          state_next.st = sweep_pkg::ST_IDLE;
        end
      end
      default: state_next.st = sweep_pkg::ST_IDLE;
    endcase
    if (!state_reg.cfg.run && state_reg.st != sweep_pkg::ST_IDLE)
    begin
      state_next.st = sweep_pkg::ST_IDLE;
      state_next.fast = 1'b0;
    end
    state_next.cap = (state_next.st == sweep_pkg::ST_PRE) || (state_next.st == sweep_pkg::ST_POST);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.cfg.len <= sweep_pkg::LEN_RESET;
      state_reg.cfg.pre <= sweep_pkg::PRE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = 1'b0;
  assign capture_en = state_reg.cap;
  assign fast_rate = state_reg.fast;
  assign desc_valid = state_reg.desc.valid;
  assign desc_marker = state_reg.desc.marker;
  assign desc_slot = state_reg.desc.slot;
  assign desc_pre = state_reg.desc.pre_kept;
  assign desc_len = state_reg.desc.length;

  pre_trunc_a: assert property (@(posedge clk) disable iff (rst)
    sweep_start && !state_reg.cfg.delay_en |=> desc_pre == $past(state_reg.pre_cnt))
    else $error("kept pre-trigger wrong");
  store_now_a: assert property (@(posedge clk) disable iff (rst)
    sweep_start |=> desc_valid && !desc_marker)
    else $error("storage not started at trigger");
  marker_only_a: assert property (@(posedge clk) disable iff (rst)
    state_reg.st == sweep_pkg::ST_PRE && state_reg.cfg.run && trig && spacing_open &&
    state_reg.slot_busy[state_reg.wr_slot] |=> desc_marker && state_reg.st == sweep_pkg::ST_PRE)
    else $error("overrun trigger started a sweep");
  spacing_a: assert property (@(posedge clk) disable iff (rst)
    sweep_start |=> !sweep_start [*8])
    else $error("sweeps too close");
  stretch_fit_a: assert property (@(posedge clk) disable iff (rst)
    stretch_go |-> (AW+1)'(state_reg.used) + (AW+1)'(state_reg.cfg.len - state_reg.cfg.pre) <=
      (AW+1)'(state_reg.cfg.len))
    else $error("stretch overflows memory");
  no_switch_a: assert property (@(posedge clk) disable iff (rst)
    state_reg.st == sweep_pkg::ST_DONE |=> !fast_rate)
    else $error("switch after sweep end");
  delay_post_a: assert property (@(posedge clk) disable iff (rst)
    sweep_start && state_reg.cfg.delay_en |=> state_reg.post_cnt == state_reg.cfg.len)
    else $error("delayed sweep not all post");
  sweep_cap_a: assert property (@(posedge clk) disable iff (rst)
    state_reg.sweeps <= sweep_pkg::CNT_W'(sweep_pkg::SWEEP_MAX))
    else $error("too many sweeps");

  sweep_start_c: cover property (@(posedge clk) sweep_start);
  stretch_c: cover property (@(posedge clk) stretch_go);
  marker_c: cover property (@(posedge clk) desc_valid && desc_marker);
  switch_c: cover property (@(posedge clk) $rose(fast_rate));

endmodule : sweep_capture_controller
